// ### design/pgs_control.sv
// control end: generates the process switching signal
`timescale 1ns/100ps
module pgs_control
  import pgs_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  pgs_if.control    link,
  input  wire logic material_near,  // tamper-resistant position: 200 mm ahead, see R9
  input  wire logic material_past,  // process position: 200 mm beyond the field
  input  wire logic belt_moving,    // supplementary plausibility input
  output logic      gating_seen
);
  import pgs_pkg::*;

  // belt and position inputs come from other logic on clk
  pgs_cnt_t ext_q;
  logic     req_q;
  logic     sw_q;
  logic [1:0] ga_sync_q;

  // time extension: position must persist before switching, never a single press, see R6
  always_ff @(posedge clk) begin
    if (reset || !(material_near && belt_moving) || material_past) begin
      ext_q <= '0;                                          // see R7
    end else if (ext_q < pgs_ms_to_cyc(T_EXT_MS)) begin
      ext_q <= ext_q + pgs_cnt_t'(1);
    end
  end
  assign req_q = (ext_q >= pgs_ms_to_cyc(T_EXT_MS));       // see R8

  // switch only from process sequence, drop once material is past
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_q <= 1'b0;
    end else if (material_past) begin
      sw_q <= 1'b0;                                         // see R5
    end else if (req_q) begin
      sw_q <= 1'b1;                                         // see R4 see R10
    end
  end
  assign link.process_switch = sw_q;

  // gating indication seen back from the receiver
  always_ff @(posedge clk) begin
    if (reset) begin
      ga_sync_q   <= 2'h0;
      gating_seen <= 1'b0;
    end else begin
      ga_sync_q   <= {ga_sync_q[0], link.gating_active};
      gating_seen <= ga_sync_q[1];
    end
  end

endmodule : pgs_control

// ### design/pgs_device.sv
// receiver end: timed process gating sequencer
`timescale 1ns/100ps
// Overview of operation
// R1: gate only if interruption within window
// R2: auto end after mode clear time
// R3: controlled end: both idle over 0.1s
// R4: control switches within 200 mm
// R5: control withdraws by 200 mm past
// R6: never from single human action
// R7: sensor input only indirectly used
// R8: switching from process sequence or extension
// R9: position source must resist tampering
// R10: check belt movement before switching
// R11: mode taken from wiring only
// R12: sync beams not blocked over 60s; not enforced, T_SYNC_MAX_MS is defined but unused
// R13: show mode number on display
// R14: missed window means normal stop
// R15: gating indication only during sequence
module pgs_device
  import pgs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  pgs_if.device                 link,
  input  wire logic             field_interrupted,
  input  wire pgs_pkg::pgs_mode_t mode_strap,
  output logic                  safety_output_ok,
  output pgs_pkg::pgs_mode_t    display_mode,
  output logic                  window_missed
);
  import pgs_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ARMED  = 4'h2,
    ST_GATING = 4'h4,
    ST_MISSED = 4'h8
  } pgs_state_t;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: pins are asynchronous to clk
  logic [1:0] sw_sync_q;
  logic [1:0] fi_sync_q;
  pgs_mode_t  mode_s1_q;
  pgs_mode_t  mode_s2_q;
  logic       sw_s;
  logic       fi_s;

  always_ff @(posedge clk) begin
    sw_sync_q <= {sw_sync_q[0], link.process_switch};
    fi_sync_q <= {fi_sync_q[0], field_interrupted};
    mode_s1_q <= mode_strap;
    mode_s2_q <= mode_s1_q;
  end
  assign sw_s = sw_sync_q[1];
  assign fi_s = fi_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // mode latched from wiring once after reset; no software path exists
  pgs_mode_t mode_q;
  logic      mode_taken_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q       <= MODE_5;
      mode_taken_q <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_q       <= mode_s2_q; // see R11
      mode_taken_q <= 1'b1;
    end
  end

  // limits chosen from the latched mode
  pgs_cnt_t t1_lim;
  pgs_cnt_t t2_lim;
  always_comb begin
    t1_lim = (mode_q == MODE_4) ? pgs_ms_to_cyc(T1_SHORT_MS)
                                : pgs_ms_to_cyc(T1_LONG_MS); // see R1
    unique case (mode_q)
      MODE_4:  t2_lim = pgs_ms_to_cyc(T2_M4_MS);  // see R2
      MODE_5:  t2_lim = pgs_ms_to_cyc(T2_M5_MS);
      default: t2_lim = pgs_ms_to_cyc(T2_M16_MS); // modes 1, 6 and unknown: slowest
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence state machine
  pgs_state_t state_q;
  pgs_cnt_t   win_q;    // time since switching signal rose
  pgs_cnt_t   clr_q;    // time field has been clear while gating
  pgs_cnt_t   idle_q;   // time both inputs idle while gating
  logic       sw_prev_q;
  logic       sw_rise;
  logic       auto_end;
  logic       ctrl_end;

  assign sw_rise  = sw_s && !sw_prev_q;
  assign auto_end = (clr_q > t2_lim);                              // see R2
  assign ctrl_end = (idle_q > pgs_ms_to_cyc(T_CTRL_END_MS));       // see R3

  always_ff @(posedge clk) begin
    if (reset) begin
      sw_prev_q <= 1'b0;
    end else begin
      sw_prev_q <= sw_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // interruption without prior switching is a normal stop
          if (sw_rise && !fi_s) state_q <= ST_ARMED;
        end
        ST_ARMED: begin
          if (fi_s) begin
            state_q <= ST_GATING;                  // see R1
          end else if (!sw_s) begin
            state_q <= ST_IDLE;
          end else if (win_q >= t1_lim) begin
            state_q <= ST_MISSED;                  // see R14
          end
        end
        ST_GATING: begin
          if (auto_end || ctrl_end) state_q <= ST_IDLE; // see R15
        end
        ST_MISSED: begin
          // a new sequence needs the switching signal withdrawn first
          if (!sw_s) state_q <= ST_IDLE;           // see R14
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // window timer runs only while armed
  always_ff @(posedge clk) begin
    if (reset || state_q != ST_ARMED) begin
      win_q <= '0;
    end else begin
      win_q <= win_q + pgs_cnt_t'(1);
    end
  end

  // clear and idle timers run only while gating
  always_ff @(posedge clk) begin
    if (reset || state_q != ST_GATING || fi_s) begin
      clr_q <= '0;
    end else begin
      clr_q <= clr_q + pgs_cnt_t'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_q != ST_GATING || fi_s || sw_s) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + pgs_cnt_t'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic gating_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      gating_q         <= 1'b0;
      safety_output_ok <= 1'b0;
      window_missed    <= 1'b0;
      display_mode     <= '0;
    end else begin
      gating_q         <= (state_q == ST_GATING) && !auto_end && !ctrl_end; // see R15
      // field clear, or bridged by gating, keeps the machine running
      safety_output_ok <= !fi_s || ((state_q == ST_GATING) && !auto_end && !ctrl_end);
      window_missed    <= (state_q == ST_MISSED);       // see R14
      display_mode     <= mode_taken_q ? mode_q : '0;  // see R13
    end
  end
  assign link.gating_active = gating_q;

endmodule : pgs_device

// ### pkg/pgs_if.sv
// interface: link between machine control and gating receiver
`timescale 1ns/100ps
interface pgs_if;
  logic process_switch;  // switching signal from control, active high
  logic gating_active;   // gating indication from receiver, active high

  modport device (input process_switch, output gating_active);
  modport control (output process_switch, input gating_active);
endinterface : pgs_if

// ### pkg/pgs_pkg.sv
// package: shared constants and types for the process gating sequencer
package pgs_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;

  // times in milliseconds, as specified
  localparam int unsigned T1_LONG_MS    = 4000;  // field interruption window, modes 1 5 6
  localparam int unsigned T1_SHORT_MS   = 2000;  // field interruption window, mode 4
  localparam int unsigned T2_M4_MS      = 500;   // clear filter, mode 4
  localparam int unsigned T2_M5_MS      = 1000;  // clear filter, mode 5
  localparam int unsigned T2_M16_MS     = 2000;  // clear filter, modes 1 and 6
  localparam int unsigned T_CTRL_END_MS = 100;   // controlled end, both inputs idle
  localparam int unsigned T_SYNC_MAX_MS = 60000; // both sync beams blocked, far side limit
  localparam int unsigned T_EXT_MS      = 100;   // control side time extension

  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CNT_W      = 34;
  typedef logic [CNT_W-1:0] pgs_cnt_t;

  // operating modes as wired; code equals displayed number
  localparam int unsigned MODE_W = 3;
  typedef logic [MODE_W-1:0] pgs_mode_t;
  localparam pgs_mode_t MODE_1 = 3'h1;
  localparam pgs_mode_t MODE_4 = 3'h4;
  localparam pgs_mode_t MODE_5 = 3'h5;
  localparam pgs_mode_t MODE_6 = 3'h6;

  // milliseconds to clock cycles
  function automatic pgs_cnt_t pgs_ms_to_cyc(input int unsigned ms);
    pgs_cnt_t c;
    c = pgs_cnt_t'(ms) * pgs_cnt_t'(CYC_PER_MS);
    return (c == '0) ? pgs_cnt_t'(1) : c;
  endfunction : pgs_ms_to_cyc

endpackage : pgs_pkg

// ### test/pgs_props.sv
// checker: gating sequence properties on the control link
`timescale 1ns/100ps
module pgs_props
  import pgs_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           process_switch,
  input wire logic           gating_active,
  input wire logic           field_interrupted,
  input wire pgs_pkg::pgs_mode_t display_mode
);
  import pgs_pkg::*;
  pgs_cnt_t clr_q;
  pgs_cnt_t idl_q;
  pgs_cnt_t t2;
  pgs_cnt_t ctl;
  //////////////////////////////////////////////////////////////////////
  // raw idle counts; the receiver lags them by its input sync
  always_ff @(posedge clk) clr_q <= (reset || field_interrupted) ? '0 : clr_q + 1'b1;
  always_ff @(posedge clk) idl_q <= (reset || field_interrupted || process_switch) ? '0
                                    : idl_q + 1'b1;
  // unknown mode codes fall back to the long filter
  assign t2  = pgs_cnt_t'(display_mode == MODE_4 ? T2_M4_MS : display_mode == MODE_5 ? T2_M5_MS
               : T2_M16_MS) * pgs_cnt_t'(CYC_PER_MS);
  assign ctl = pgs_cnt_t'(T_CTRL_END_MS) * pgs_cnt_t'(CYC_PER_MS);
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  rise_cause_a: assert property ($rose(gating_active) |->
    $past(field_interrupted, 4) && $past(process_switch, 5)) else $error("gating without cause");
  no_field_a: assert property (!field_interrupted[*6] |-> !$rose(gating_active))
    else $error("gating rose on clear field");
  no_switch_a: assert property (!process_switch[*8] |-> !$rose(gating_active))
    else $error("gating rose without switch");
  hold_a: assert property (field_interrupted[*4] ##0 gating_active |=> gating_active)
    else $error("gating dropped while field broken");
  end_min_a: assert property ($fell(gating_active) |-> clr_q > t2 || idl_q > ctl)
    else $error("gating ended too early");
  end_auto_a: assert property (clr_q == t2 + 8 |-> !gating_active)
    else $error("gating outlived field filter");
  end_ctrl_a: assert property (idl_q == ctl + 8 |-> !gating_active)
    else $error("gating outlived controlled end");
  mode_keep_a: assert property (display_mode != '0 |=> $stable(display_mode))
    else $error("mode changed after latch");
  cover property ($rose(gating_active));
  cover property (field_interrupted && !process_switch);
  cover property (process_switch && !gating_active);
endmodule : pgs_props

// ### test/process_gating_sequencer_tb.sv
// bench: control and receiver ends, plus a receiver driven directly
`timescale 1ns/100ps
module process_gating_sequencer_tb;
  import pgs_pkg::*;
  logic      clk, reset, fld, fld_b, near, past, belt, gseen, ok_b, miss_b, ok_a, miss_a;
  pgs_mode_t disp_a, disp_b;
  int        bad_count, checks_done, cyc;
  pgs_if link_a();
  pgs_if link_b();
  //////////////////////////////////////////////////////////////////////
  pgs_control pgs_control_inst (.clk(clk), .reset(reset), .link(link_a.control),
    .material_near(near), .material_past(past), .belt_moving(belt), .gating_seen(gseen));
  pgs_device pgs_device_inst (.clk(clk), .reset(reset), .link(link_a.device),
    .field_interrupted(fld), .mode_strap(MODE_6), .safety_output_ok(ok_a), .display_mode(disp_a),
    .window_missed(miss_a));
  // second receiver: bench plays the control so timing is ours
  pgs_device pgs_device_inst_b (.clk(clk), .reset(reset), .link(link_b.device),
    .field_interrupted(fld_b), .mode_strap(MODE_4), .safety_output_ok(ok_b),
    .display_mode(disp_b), .window_missed(miss_b));
  pgs_props pgs_props_inst (.clk(clk), .reset(reset), .process_switch(link_a.process_switch),
    .gating_active(link_a.gating_active), .field_interrupted(fld), .display_mode(disp_a));
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // inputs change at the falling edge, then n cycles pass
  task automatic drive(input logic sw, input logic f, input int n);
    @(negedge clk);
    link_b.process_switch = sw;
    fld_b = f;
    repeat (n) @(negedge clk);
  endtask : drive
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // hang guard; full second-scale timings are out of reach here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    {reset, fld, fld_b, near, past, belt} = 6'h20;
    link_b.process_switch = 1'b0;
    {bad_count, checks_done, cyc} = '0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    drive(1'b0, 1'b0, 3);
    check(disp_a, MODE_6);
    check(ok_b, 1'b1);
    check(disp_b, MODE_4);
    // broken field with no switching signal is a plain stop
    drive(1'b0, 1'b1, 20);
    check(link_b.gating_active, 1'b0);
    check(ok_b, 1'b0);
    drive(1'b0, 1'b0, 10);
    drive(1'b1, 1'b0, 6);
    check(link_b.gating_active, 1'b0);
    drive(1'b1, 1'b1, 8);
    check(link_b.gating_active, 1'b1);
    check(ok_b, 1'b1);
    // switch withdrawn, field still broken: bridge holds
    drive(1'b0, 1'b1, 50);
    check(link_b.gating_active, 1'b1);
    check(miss_b, 1'b0);
    // control must not switch without belt movement or before its extension
    near = 1'b1;
    fld = 1'b1; // blocked far below the sync beam limit
    repeat (300) @(negedge clk);
    check(ok_a, 1'b0);
    check(miss_a, 1'b0);
    check(link_a.process_switch, 1'b0);
    check(link_a.gating_active, 1'b0);
    belt = 1'b1;
    repeat (2000) @(negedge clk);
    check(link_a.process_switch, 1'b0);
    check(gseen, 1'b0);
    // reset in mid-gating clears the bridge and relatches the mode
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check(link_b.gating_active, 1'b0);
    reset = 1'b0;
    drive(1'b0, 1'b0, 4);
    check(disp_b, MODE_4);
    test_done();
  end
endmodule : process_gating_sequencer_tb
